// [design/dpio_rst_sync.sv]
// Reset release synchroniser
`timescale 1ns/1ps
module dpio_rst_sync (
  // Clock and raw reset
  input wire logic clock,
  input wire logic nrst,
  // Synchronised reset
  output logic rst_n
);
  logic stage_n;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stage_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      stage_n <= 1'b1;
      rst_n <= stage_n;
    end
  end
endmodule

// [design/dpio_sync.sv]
// Two flip-flop synchroniser for a bus of pin levels
`timescale 1ns/1ps
module dpio_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        meta[i] <= 1'b0;
        q[i] <= 1'b0;
      end else begin
        meta[i] <= d[i];
        q[i] <= meta[i];
      end
    end
  end
endmodule

// [design/dpio_top.sv]
// Two 8-bit general purpose ports, pull-ups on port A only, bus reuse and a Wishbone register slave
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ps
module dpio_top
  import dpio_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Mode strap and standby
  input wire logic [1:0] op_mode,
  input wire logic hw_standby,
  input wire logic wake,
  output logic periph_reset,
  // External data bus use of port A
  input wire logic [7:0] ext_bus_out,
  input wire logic ext_bus_oe,
  output logic [7:0] ext_bus_in,
  // Host data bus use of port A
  input wire logic [7:0] host_bus_out,
  input wire logic host_bus_oe,
  output logic [7:0] host_bus_in,
  // Port A pins
  input wire logic [7:0] pa_in,
  output logic [7:0] pa_out,
  output logic [7:0] pa_oe,
  output logic [7:0] pa_pullup,
  // Port B alternate functions
  input wire logic [7:0] periph_en,
  input wire logic [7:0] periph_out,
  input wire logic [7:0] slave_fn_en,
  input wire logic [7:0] slave_fn_out,
  input wire logic clk_out_level,
  output logic host_cs_in,
  // Port B pins
  input wire logic [7:0] pb_in,
  output logic [7:0] pb_out,
  output logic [7:0] pb_oe
);
  logic rst_n;
  logic [7:0] pa_sync;
  logic [7:0] pb_sync;
  dpio_mode_t mode;
  logic mode_taken;
  logic [7:0] a_lat;
  logic [7:0] a_pcr;
  logic [7:0] a_dir;
  logic [7:0] b_lat;
  logic [7:0] b_dir;
  logic host_if_enable_bit;
  logic sw_stby;
  logic mode12;
  logic slave;
  logic [7:0] b_dir_eff;
  logic [IW-1:0] idx;
  logic req;
  logic wr;
  logic [7:0] wbyte;
  logic [7:0] rd_byte;
  logic [7:0] next_pa_out;
  logic [7:0] next_pa_oe;
  logic [7:0] next_pa_pu;
  logic [7:0] next_pb_out;
  logic [7:0] next_pb_oe;

  dpio_rst_sync u_rst (
    .clock(clock),
    .nrst(nrst),
    .rst_n(rst_n)
  );

  dpio_sync #(.W(8)) u_sync_a (
    .clock(clock),
    .rst_n(rst_n),
    .d(pa_in),
    .q(pa_sync)
  );

  dpio_sync #(.W(8)) u_sync_b (
    .clock(clock),
    .rst_n(rst_n),
    .d(pb_in),
    .q(pb_sync)
  );

  // Mode strap caught once after reset release
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode <= DPIO_MODE3;
      mode_taken <= 1'b0;
    end else if (!mode_taken) begin
      mode <= dpio_mode_t'(op_mode);
      mode_taken <= 1'b1;
    end
  end

  assign mode12 = (mode == DPIO_MODE1) || (mode == DPIO_MODE2);
  assign slave = (mode == DPIO_MODE3) && host_if_enable_bit;
  assign b_dir_eff = mode12 ? (b_dir | B_DIR_FORCE) : b_dir;

  // Bus decode
  assign idx = wb_adr_i[AW-1:2];
  assign req = wb_cyc_i && wb_stb_i;
  assign wr = req && wb_we_i && wb_ack_o && wb_sel_i[0];
  assign wbyte = wb_dat_i[7:0];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req && !wb_ack_o;
    end
  end

  always_comb begin
    rd_byte = RD_NONE;
    unique case (idx)
      IDX_A_LAT: rd_byte = (a_dir & a_lat) | (~a_dir & pa_sync);
      IDX_A_DIR: rd_byte = RD_WRITE_ONLY;
      IDX_A_PCR: rd_byte = a_pcr;
      IDX_B_DIR: rd_byte = RD_WRITE_ONLY;
      IDX_B_LAT: begin
        rd_byte = (b_dir_eff & b_lat) | (~b_dir_eff & pb_sync);
        rd_byte[B_CLK_PIN] = pb_sync[B_CLK_PIN];
      end
      IDX_SYS: begin
        rd_byte[SYS_HIE] = host_if_enable_bit;
        rd_byte[SYS_SWSTBY] = sw_stby;
        rd_byte[SYS_MODE+:2] = mode;
      end
      default: rd_byte = RD_NONE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && !wb_ack_o) begin
      wb_dat_o <= {24'h00_0000, rd_byte};
    end
  end

  // Port A latch
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      a_lat <= RST_A_LAT;
    end else if (hw_standby) begin
      a_lat <= RST_A_LAT;
    end else if (wr && idx == IDX_A_LAT) begin
      a_lat <= wbyte;
    end
  end

  // Port A pull-up control
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      a_pcr <= RST_A_PCR;
    end else if (hw_standby) begin
      a_pcr <= RST_A_PCR;
    end else if (wr && idx == IDX_A_PCR) begin
      a_pcr <= wbyte;
    end
  end

  // Port A direction
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      a_dir <= RST_A_DIR;
    end else if (hw_standby) begin
      a_dir <= RST_A_DIR;
    end else if (wr && idx == IDX_A_DIR) begin
      a_dir <= wbyte;
    end
  end

  // Port B latch; bit 6 has no storage that can be read
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      b_lat <= RST_B_LAT;
    end else if (hw_standby) begin
      b_lat <= RST_B_LAT;
    end else if (wr && idx == IDX_B_LAT) begin
      b_lat <= wbyte & ~B_DIR_FORCE;
    end
  end

  // Port B direction; bit 6 forced in modes 1 and 2
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      b_dir <= RST_B_DIR;
    end else if (hw_standby) begin
      b_dir <= RST_B_DIR;
    end else if (wr && idx == IDX_B_DIR) begin
      b_dir <= wbyte;
    end
  end

  // System control: host interface enable and software standby
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      host_if_enable_bit <= 1'b0;
      sw_stby <= 1'b0;
    end else if (hw_standby) begin
      host_if_enable_bit <= 1'b0;
      sw_stby <= 1'b0;
    end else if (wr && idx == IDX_SYS) begin
      host_if_enable_bit <= wbyte[SYS_HIE];
      sw_stby <= wbyte[SYS_SWSTBY];
    end else if (wake) begin
      sw_stby <= 1'b0;
    end
  end

  assign periph_reset = sw_stby;

  // Port A pin control
  always_comb begin
    next_pa_out = a_lat;
    next_pa_oe = a_dir;
    if (mode12) begin
      next_pa_out = ext_bus_out;
      next_pa_oe = {8{ext_bus_oe && !sw_stby}};
    end else if (slave) begin
      next_pa_out = host_bus_out;
      next_pa_oe = {8{host_bus_oe}};
    end
    if (hw_standby) begin
      next_pa_oe = 8'h00;
    end
  end

  always_comb begin
    next_pa_pu = a_pcr & ~a_dir;
    if (mode == DPIO_MODE1 || slave || hw_standby) begin
      next_pa_pu = 8'h00;
    end
  end

  // Port B pin control
  always_comb begin
    next_pb_out = b_lat;
    next_pb_oe = b_dir_eff;
    for (int i = 0; i < 8; i++) begin
      if (i != B_CLK_PIN) begin
        if (periph_en[i] && !sw_stby) begin
          next_pb_out[i] = periph_out[i];
          next_pb_oe[i] = 1'b1;
        end else if (slave_fn_en[i] && slave && b_dir_eff[i]) begin
          next_pb_out[i] = slave_fn_out[i];
        end
      end
    end
    next_pb_out[B_CLK_PIN] = clk_out_level;
    if (slave) begin
      next_pb_oe[B_CLK_PIN] = 1'b0;
    end
    if (hw_standby) begin
      next_pb_oe = 8'h00;
    end
  end

  assign host_cs_in = slave && pb_sync[B_CLK_PIN];
  assign ext_bus_in = pa_sync;
  assign host_bus_in = pa_sync;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pa_out <= 8'h00;
      pa_oe <= 8'h00;
      pa_pullup <= 8'h00;
      pb_out <= 8'h00;
      pb_oe <= 8'h00;
    end else begin
      pa_out <= next_pa_out;
      pa_oe <= next_pa_oe;
      pa_pullup <= next_pa_pu;
      pb_out <= next_pb_out;
      pb_oe <= next_pb_oe;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  pullup_cond_a: assert property (
    pa_pullup != 8'h00 |-> $past(a_pcr & ~a_dir) != 8'h00)
    else $error("pull-up on without its condition");

  slave_pullup_a: assert property (
    slave && $past(slave) |-> pa_pullup == 8'h00)
    else $error("pull-up on in slave mode");

  mode1_pullup_a: assert property (
    mode == DPIO_MODE1 && $past(mode) == DPIO_MODE1 |-> pa_pullup == 8'h00)
    else $error("pull-up on in mode 1");

  hw_clear_a: assert property (
    hw_standby |=> a_lat == RST_A_LAT && a_pcr == RST_A_PCR)
    else $error("hardware standby did not clear port A");

  b_dir_read_a: assert property (
    req && !wb_we_i && !wb_ack_o && idx == IDX_B_DIR |=> wb_ack_o && wb_dat_o[7:0] == 8'hff)
    else $error("port B direction read not all ones");

  b_pin6_read_a: assert property (
    req && !wb_we_i && !wb_ack_o && idx == IDX_B_LAT |=> wb_dat_o[6] == $past(pb_sync[6]))
    else $error("port B bit 6 read not pin level");

  pin6_dir_a: assert property (
    mode12 && !hw_standby ##1 mode12 |-> pb_oe[6])
    else $error("pin 6 not driving in modes 1 and 2");

  ext_bus_a: assert property (
    mode12 && !hw_standby && !sw_stby ##1 mode12 |-> pa_oe == {8{$past(ext_bus_oe)}})
    else $error("port A not following external bus");

  ack_pulse_a: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  swstby_hold_a: assert property (
    sw_stby && !hw_standby && !(wr && idx == IDX_B_DIR) |=> $stable(b_dir))
    else $error("port B direction changed in software standby");
endmodule

// [shared/dpio_pkg.sv]
// Constants and types for the dual port I/O block
package dpio_pkg;
  localparam int AW = 18;
  localparam int IW = 16;
  // Register indices; byte address is four times the index
  localparam logic [IW-1:0] IDX_A_DIR = 16'hffb4;
  localparam logic [IW-1:0] IDX_B_DIR = 16'hffb5;
  localparam logic [IW-1:0] IDX_A_LAT = 16'hffb6;
  localparam logic [IW-1:0] IDX_B_LAT = 16'hffb7;
  localparam logic [IW-1:0] IDX_A_PCR = 16'hffae;
  localparam logic [IW-1:0] IDX_SYS = 16'hffc0;
  // Reset values, the forced port B direction bit and fixed read values
  localparam logic [7:0] RST_A_LAT = 8'h00;
  localparam logic [7:0] RST_A_PCR = 8'h00;
  localparam logic [7:0] RST_A_DIR = 8'h00;
  localparam logic [7:0] RST_B_LAT = 8'h00;
  localparam logic [7:0] RST_B_DIR = 8'h00;
  localparam logic [7:0] B_DIR_FORCE = 8'h40;
  localparam logic [7:0] RD_WRITE_ONLY = 8'hff;
  localparam logic [7:0] RD_NONE = 8'h00;
  // Field positions
  localparam int B_CLK_PIN = 6;
  localparam int SYS_HIE = 0;
  localparam int SYS_SWSTBY = 1;
  localparam int SYS_MODE = 2;
  typedef enum logic [1:0] {
    DPIO_MODE0 = 2'h0,
    DPIO_MODE1 = 2'h1,
    DPIO_MODE3 = 2'h3,
    DPIO_MODE2 = 2'h2
  } dpio_mode_t;
endpackage

// [verification/dpio_pins.sv]
// Pin-side model: resolves each port wire from the device, an outside driver and the pull-ups
`timescale 1ns/1ps
module dpio_pins (
  // Clock
  input wire logic clock,
  // Device side
  input wire logic [7:0] drv_out,
  input wire logic [7:0] drv_oe,
  input wire logic [7:0] pu_en,
  // Outside driver
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  // Wire level
  output logic [7:0] pin
);
  logic [7:0] last = 8'h00;
  // A floating wire without pull-up shows the inverse of its last level
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (drv_oe[i]) pin[i] = drv_out[i];
      else if (ext_en[i]) pin[i] = ext_val[i];
      else if (pu_en[i]) pin[i] = 1'b1;
      else pin[i] = ~last[i];
    end
  end
  always_ff @(posedge clock) begin
    last <= pin;
  end
endmodule

// [verification/dpio_top_bench.sv]
// Register-level testbench for the dual port I/O block
`timescale 1ns/1ps
module dpio_top_bench;
  import dpio_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o, periph_reset, host_cs_in;
  logic [AW-1:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic [1:0] op_mode = 2'h3;
  logic hw_standby = 1'b0, wake = 1'b0, ext_bus_oe = 1'b0, host_bus_oe = 1'b0, clk_out_level = 1'b1;
  logic [7:0] ext_bus_out = 8'h00, host_bus_out = 8'h00, periph_en = 8'h00, periph_out = 8'h00;
  logic [7:0] slave_fn_en = 8'h02, slave_fn_out = 8'h02, a_drv = 8'h00, b_drv = 8'h00;
  logic [7:0] ext_bus_in, host_bus_in, pa_in, pa_out, pa_oe, pa_pullup, pb_in, pb_out, pb_oe, rd;
  int fails = 0;
  int total_checks = 0;
  always #2.5 clock = ~clock;
  dpio_top dpio_top_i (.clock(clock), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .op_mode(op_mode), .hw_standby(hw_standby), .wake(wake), .periph_reset(periph_reset),
    .ext_bus_out(ext_bus_out), .ext_bus_oe(ext_bus_oe), .ext_bus_in(ext_bus_in), .host_bus_out(host_bus_out),
    .host_bus_oe(host_bus_oe), .host_bus_in(host_bus_in), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe),
    .pa_pullup(pa_pullup), .periph_en(periph_en), .periph_out(periph_out), .slave_fn_en(slave_fn_en),
    .slave_fn_out(slave_fn_out), .clk_out_level(clk_out_level), .host_cs_in(host_cs_in), .pb_in(pb_in),
    .pb_out(pb_out), .pb_oe(pb_oe));
  dpio_pins dpio_pins_a_i (.clock(clock), .drv_out(pa_out), .drv_oe(pa_oe), .pu_en(pa_pullup),
    .ext_val(a_drv), .ext_en(8'hff), .pin(pa_in));
  dpio_pins dpio_pins_b_i (.clock(clock), .drv_out(pb_out), .drv_oe(pb_oe), .pu_en(8'h00),
    .ext_val(b_drv), .ext_en(8'hff), .pin(pb_in));
  task automatic end_sim;
    $display("Checks made %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [IW-1:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h00_0000, wd};
    // Ack is sampled at the rising edge; the write lands and read data is taken there
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      fails++;
      $display("unexpected at %0t: no acknowledge", $time);
      end_sim();
    end else begin
      rd = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
    end
  endtask
  task automatic rdchk(input logic [IW-1:0] idx, input logic [7:0] exp);
    wb(1'b0, idx, 8'h00);
    chk(rd, exp);
  endtask
  task automatic settle;
    repeat (4) @(posedge clock);
    @(negedge clock);
  endtask
  task automatic do_reset(input logic [1:0] m);
    @(posedge clock);
    nrst <= 1'b0;
    op_mode <= m;
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    repeat (6) @(posedge clock);
  endtask
  initial begin
    for (int m = 1; m <= 3; m++) begin
      do_reset(2'(m));
      settle();
      chk(pb_oe, (m == 3) ? RST_B_DIR : B_DIR_FORCE);
      chk(pb_in & 8'h40, (m == 3) ? 8'h00 : 8'h40);
      rdchk(IDX_B_DIR, RD_WRITE_ONLY);
      rdchk(IDX_A_PCR, RST_A_PCR);
      wb(1'b1, IDX_B_DIR, 8'h03);
      wb(1'b1, IDX_B_LAT, 8'h01);
      wb(1'b1, IDX_A_PCR, 8'hff);
      ext_bus_oe <= 1'b1;
      ext_bus_out <= 8'h3c;
      settle();
      chk(pb_oe, (m == 3) ? 8'h03 : 8'h43);
      chk(pb_out & 8'h03, 8'h01);
      chk(pa_pullup, (m == 1) ? 8'h00 : 8'hff);
      chk(pa_oe, (m == 3) ? 8'h00 : 8'hff);
      chk(pa_out, (m == 3) ? 8'h00 : 8'h3c);
      chk(ext_bus_in, (m == 3) ? 8'h00 : 8'h3c);
      $display("Mode %0d test done", m);
    end
    wb(1'b1, IDX_A_DIR, 8'h0f);
    wb(1'b1, IDX_A_LAT, 8'h5a);
    wb(1'b1, IDX_B_LAT, 8'h41);
    a_drv <= 8'hc3;
    b_drv <= 8'hc6;
    periph_en <= 8'h01;
    settle();
    chk(pa_oe, 8'h0f);
    chk(pa_out & 8'h0f, 8'h0a);
    chk(pa_pullup, 8'hf0);
    chk(pb_out & 8'h01, 8'h00);
    rdchk(IDX_A_LAT, 8'hca);
    rdchk(IDX_B_LAT, 8'hc5);
    $display("General I/O test done");
    wb(1'b1, IDX_SYS, 8'h02);
    settle();
    chk({7'h00, periph_reset}, 8'h01);
    chk(pb_out & 8'h01, 8'h01);
    chk(pb_oe, 8'h03);
    chk(pa_pullup, 8'hf0);
    rdchk(IDX_A_LAT, 8'hca);
    wake <= 1'b1;
    @(posedge clock);
    wake <= 1'b0;
    settle();
    chk({7'h00, periph_reset}, 8'h00);
    $display("Software standby test done");
    wb(1'b1, IDX_A_LAT, 8'h00);
    wb(1'b1, IDX_A_DIR, 8'h00);
    wb(1'b1, IDX_SYS, 8'h01);
    host_bus_oe <= 1'b1;
    host_bus_out <= 8'h96;
    settle();
    chk(pa_pullup, 8'h00);
    chk(pa_out, 8'h96);
    chk(pa_oe, 8'hff);
    chk(host_bus_in, 8'h96);
    chk(pb_out & 8'h02, 8'h02);
    chk({7'h00, host_cs_in}, 8'h01);
    $display("Slave mode test done");
    wb(1'b1, IDX_A_LAT, 8'h5a);
    host_bus_oe <= 1'b0;
    hw_standby <= 1'b1;
    settle();
    chk(pa_pullup, 8'h00);
    chk(pb_oe, RST_B_DIR);
    @(posedge clock);
    hw_standby <= 1'b0;
    wb(1'b1, IDX_A_DIR, 8'hff);
    rdchk(IDX_A_LAT, RST_A_LAT);
    rdchk(IDX_A_PCR, RST_A_PCR);
    rdchk(16'h0000, RD_NONE);
    $display("Hardware standby test done");
    end_sim();
  end
endmodule
